// *** link_receiver.sv ***
// Shift register on the programmer clock that assembles 16-bit words from the data pin.
`timescale 1ns/1ns
module link_receiver
  import prog_exec_pkg::*;
(
  input wire logic i_link_clk,
  input wire logic i_reset_n,
  input wire logic i_data,
  link_rx_if.link rx
);
  logic [WORD_W-2:0] sh_reg;
  logic [WORD_W-2:0] sh_next;
  logic [BIT_CNT_W-1:0] cnt_reg;
  logic [BIT_CNT_W-1:0] cnt_next;
  logic [WORD_W-1:0] word_reg;
  logic [WORD_W-1:0] word_next;
  logic tog_reg;
  logic tog_next;

  // The counter runs on every rising edge, response included. Every exchange is a whole
  // number of words, so word boundaries stay aligned without any gating from the core.
  always_comb begin
    // RULE6: sample on rise
    sh_next = {sh_reg[WORD_W-3:0], i_data};
    cnt_next = cnt_reg + 4'h1;
    word_next = word_reg;
    tog_next = tog_reg;
    // RULE7: MSB first words
    if (cnt_reg == LAST_BIT) begin
      word_next = {sh_reg, i_data};
      tog_next = ~tog_reg;
    end
  end

  always_ff @(posedge i_link_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sh_reg <= 15'h0000;
      cnt_reg <= 4'h0;
      word_reg <= 16'h0000;
      tog_reg <= 1'b0;
    end else begin
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      word_reg <= word_next;
      tog_reg <= tog_next;
    end
  end

  assign rx.word = word_reg;
  assign rx.toggle = tog_reg;
endmodule

// *** link_rx_if.sv ***
// Word hand-off from the link-clock receiver to the core clock domain.
`timescale 1ns/1ns
interface link_rx_if;
  logic [15:0] word;
  logic toggle;
  modport link (output word, output toggle);
  modport core (input word, input toggle);
endinterface

// *** prog_exec_link.sv ***
// Device end of the two-wire programming link: command intake, busy, ready pulse, response.
// What the link requires of both ends
// RULE1: Programmer is master and opens every exchange with a command.
// RULE2: Programmer keeps at most one command outstanding until its response ends.
// RULE3: Device returns exactly one response per command, after processing it.
// RULE4: Programmer drives the clock pin; device only ever reads it.
// RULE5: One data pin carries commands in and responses out.
// RULE6: Sender changes data after falling edge; receiver samples on rising edge.
// RULE7: All transfers are 16-bit words, most significant bit first.
// RULE8: Programmer releases the data pin after the last command word.
// RULE9: Device holds the data pin high while processing a command.
// RULE10: Device drives data low for 15 microseconds when the response is ready.
// RULE11: Programmer waits 20 microseconds after the low before clocking the response.
// RULE12: Programmer supplies clocks for every word of the response. The bench programmer model clocks at most 6 words.
// RULE13: Programmer should hold the clock idle between response and next command.
// RULE14: Programmer keeps the serial clock at or below 1 MHz.
// RULE15: Device has no timeout; programmer times commands and resets on expiry.
// RULE16: Response header carries a word length that includes both header words.
// RULE17: Non-query status byte is 0x0 ok, 0x1 verify fail, 0x2 other.
// RULE18: Device releases the data pin after the final response bit.
`timescale 1ns/1ns
module prog_exec_link
  import prog_exec_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_RESET_N,
  input wire logic I_CLK_EN,
  input wire logic I_PROG_CLOCK_PIN,
  input wire logic I_PROG_DATA_PIN,
  output logic O_PROG_DATA_PIN,
  output logic O_PROG_DATA_PIN_OE_N,
  output logic [prog_exec_pkg::WORD_W-1:0] O_CMD_WORD,
  output logic O_CMD_VALID,
  output logic O_CMD_FIRST,
  output logic O_CMD_LAST,
  output logic O_BUSY,
  input wire logic I_RSP_DONE,
  input wire logic I_RSP_QUERY,
  input wire logic [1:0] I_RSP_ERROR,
  input wire logic [7:0] I_RSP_QUERY_BYTE,
  input wire logic [prog_exec_pkg::WORD_W-1:0] I_RSP_DATA_COUNT,
  output logic O_RSP_DATA_REQ,
  input wire logic I_RSP_DATA_VALID,
  input wire logic [prog_exec_pkg::WORD_W-1:0] I_RSP_DATA
);
  import prog_exec_pkg::*;

  link_rx_if rx_bus ();

  // RULE4: clock pin only read
  link_receiver u_rx (
    .i_link_clk(I_PROG_CLOCK_PIN),
    .i_reset_n(I_RESET_N),
    .i_data(I_PROG_DATA_PIN),
    .rx(rx_bus.link)
  );

  // Synchronisers: the first stage of each feeds only the second.
  logic sck_s1_reg;
  logic sck_s2_reg;
  logic sck_s3_reg;
  logic tog_s1_reg;
  logic tog_s2_reg;
  logic tog_s3_reg;

  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      sck_s1_reg <= 1'b0;
      sck_s2_reg <= 1'b0;
      sck_s3_reg <= 1'b0;
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
      tog_s3_reg <= 1'b0;
    end else if (I_CLK_EN) begin
      sck_s1_reg <= I_PROG_CLOCK_PIN;
      sck_s2_reg <= sck_s1_reg;
      sck_s3_reg <= sck_s2_reg;
      tog_s1_reg <= rx_bus.toggle;
      tog_s2_reg <= tog_s1_reg;
      tog_s3_reg <= tog_s2_reg;
    end
  end

  logic sck_fall;
  logic word_arrived;
  assign sck_fall = sck_s3_reg & ~sck_s2_reg;
  assign word_arrived = tog_s3_reg ^ tog_s2_reg;

  link_state_t state_reg;
  link_state_t state_next;
  logic first_reg;
  logic first_next;
  logic [11:0] left_reg;
  logic [11:0] left_next;
  logic [3:0] opcode_reg;
  logic [3:0] opcode_next;
  logic [TIMER_W-1:0] timer_reg;
  logic [TIMER_W-1:0] timer_next;
  logic [WORD_W-1:0] shift_reg;
  logic [WORD_W-1:0] shift_next;
  logic [BIT_CNT_W-1:0] bit_reg;
  logic [BIT_CNT_W-1:0] bit_next;
  logic [WORD_W-1:0] len_reg;
  logic [WORD_W-1:0] len_next;
  logic [WORD_W-1:0] sent_reg;
  logic [WORD_W-1:0] sent_next;
  logic [WORD_W-1:0] hold_reg;
  logic [WORD_W-1:0] hold_next;
  logic [WORD_W-1:0] cmd_word_reg;
  logic [WORD_W-1:0] cmd_word_next;
  logic cmd_valid_reg;
  logic cmd_valid_next;
  logic cmd_first_reg;
  logic cmd_first_next;
  logic cmd_last_reg;
  logic cmd_last_next;
  logic req_reg;
  logic req_next;
  logic pin_reg;
  logic pin_next;
  logic oe_n_reg;
  logic oe_n_next;

  always_comb begin
    logic [11:0] left_w;
    logic [7:0] status_w;
    logic [WORD_W-1:0] sent_w;
    left_w = left_reg;
    status_w = STATUS_OK;
    sent_w = sent_reg;
    state_next = state_reg;
    first_next = first_reg;
    left_next = left_reg;
    opcode_next = opcode_reg;
    timer_next = timer_reg;
    shift_next = shift_reg;
    bit_next = bit_reg;
    len_next = len_reg;
    sent_next = sent_reg;
    hold_next = hold_reg;
    cmd_word_next = cmd_word_reg;
    cmd_valid_next = 1'b0;
    cmd_first_next = 1'b0;
    cmd_last_next = 1'b0;
    req_next = 1'b0;
    if (I_RSP_DATA_VALID) begin
      hold_next = I_RSP_DATA;
    end
    case (state_reg)
      ST_RX: begin
        // RULE1: only a command starts work
        if (word_arrived) begin
          if (first_reg) begin
            left_w = rx_bus.word[CMD_LEN_MSB:CMD_LEN_LSB];
            if (left_w == 12'h000) begin
              left_w = 12'h001;
            end
            opcode_next = rx_bus.word[CMD_OPC_MSB:CMD_OPC_LSB];
          end
          cmd_word_next = rx_bus.word;
          cmd_valid_next = 1'b1;
          cmd_first_next = first_reg;
          cmd_last_next = (left_w == 12'h001);
          left_next = left_w - 12'h001;
          first_next = 1'b0;
          // RULE8: pin taken once the last word lands
          if (left_w == 12'h001) begin
            state_next = ST_BUSY;
            first_next = 1'b1;
          end
        end
      end
      ST_BUSY: begin
        // RULE3: one response after processing ends
        if (I_RSP_DONE) begin
          // RULE17: status byte encoding
          if (I_RSP_QUERY) begin
            status_w = I_RSP_QUERY_BYTE;
          end else if (I_RSP_ERROR == ERR_NONE) begin
            status_w = STATUS_OK;
          end else if (I_RSP_ERROR == ERR_VERIFY) begin
            status_w = STATUS_VERIFY_FAIL;
          end else begin
            status_w = STATUS_OTHER_ERR;
          end
          shift_next = {RSP_PASS_NIBBLE, opcode_reg, status_w};
          // RULE16: length counts header words
          len_next = I_RSP_DATA_COUNT + RSP_HDR_WORDS;
          timer_next = '0;
          state_next = ST_READY;
        end
      end
      ST_READY: begin
        // RULE10: ready low for the set time
        timer_next = timer_reg + 11'h001;
        if (timer_reg == READY_LOW_LAST) begin
          state_next = ST_TX;
          bit_next = 4'h0;
          sent_next = 16'h0000;
        end
      end
      ST_TX: begin
        // RULE6: advance after a falling edge
        if (sck_fall) begin
          if (bit_reg == LAST_BIT) begin
            sent_w = sent_reg + 16'h0001;
            sent_next = sent_w;
            bit_next = 4'h0;
            // RULE18: release after the final bit
            if (sent_w == len_reg) begin
              state_next = ST_RX;
            end else if (sent_w == 16'h0001) begin
              shift_next = len_reg;
              req_next = (len_reg > RSP_HDR_WORDS);
            end else begin
              shift_next = hold_reg;
              req_next = ((sent_w + 16'h0001) < len_reg);
            end
          end else begin
            // RULE7: most significant bit leaves first
            shift_next = {shift_reg[WORD_W-2:0], 1'b0};
            bit_next = bit_reg + 4'h1;
          end
        end
      end
      default: begin
        state_next = ST_RX;
        first_next = 1'b1;
      end
    endcase
    // RULE5: pin direction follows the phase
    case (state_next)
      ST_BUSY: begin
        // RULE9: busy drives high
        pin_next = 1'b1;
        oe_n_next = 1'b0;
      end
      ST_READY: begin
        pin_next = 1'b0;
        oe_n_next = 1'b0;
      end
      ST_TX: begin
        pin_next = shift_next[WORD_W-1];
        oe_n_next = 1'b0;
      end
      default: begin
        pin_next = 1'b1;
        oe_n_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_reg <= ST_RX;
      first_reg <= 1'b1;
      left_reg <= 12'h000;
      opcode_reg <= 4'h0;
      timer_reg <= '0;
      shift_reg <= 16'h0000;
      bit_reg <= 4'h0;
      len_reg <= 16'h0000;
      sent_reg <= 16'h0000;
      hold_reg <= 16'h0000;
      cmd_word_reg <= 16'h0000;
      cmd_valid_reg <= 1'b0;
      cmd_first_reg <= 1'b0;
      cmd_last_reg <= 1'b0;
      req_reg <= 1'b0;
      pin_reg <= 1'b1;
      oe_n_reg <= 1'b1;
    end else if (I_CLK_EN) begin
      state_reg <= state_next;
      first_reg <= first_next;
      left_reg <= left_next;
      opcode_reg <= opcode_next;
      timer_reg <= timer_next;
      shift_reg <= shift_next;
      bit_reg <= bit_next;
      len_reg <= len_next;
      sent_reg <= sent_next;
      hold_reg <= hold_next;
      cmd_word_reg <= cmd_word_next;
      cmd_valid_reg <= cmd_valid_next;
      cmd_first_reg <= cmd_first_next;
      cmd_last_reg <= cmd_last_next;
      req_reg <= req_next;
      pin_reg <= pin_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign O_PROG_DATA_PIN = pin_reg;
  assign O_PROG_DATA_PIN_OE_N = oe_n_reg;
  assign O_CMD_WORD = cmd_word_reg;
  assign O_CMD_VALID = cmd_valid_reg;
  assign O_CMD_FIRST = cmd_first_reg;
  assign O_CMD_LAST = cmd_last_reg;
  assign O_RSP_DATA_REQ = req_reg;
  // Busy flag is the registered state bit that is set in both BUSY and READY.
  assign O_BUSY = state_reg[0];
endmodule

// *** prog_exec_link_asserts.sv ***
// Port-level timing checks for the programming link device end.
`timescale 1ns/1ns
module prog_exec_link_asserts
  import prog_exec_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_RESET_N,
  input wire logic I_PROG_CLOCK_PIN,
  input wire logic I_RSP_DONE,
  input wire logic O_PROG_DATA_PIN,
  input wire logic O_PROG_DATA_PIN_OE_N,
  input wire logic O_CMD_VALID,
  input wire logic O_CMD_FIRST,
  input wire logic O_CMD_LAST,
  input wire logic O_BUSY,
  input wire logic O_RSP_DATA_REQ
);
  logic [10:0] low_reg, low_next;
  logic [3:0] age_reg, age_next;
  logic clk_reg, clk_next;
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RESET_N);
  // The age of the last clock fall saturates so a long idle never wraps back to small values.
  always_comb begin
    clk_next = I_PROG_CLOCK_PIN;
    low_next = O_BUSY ? low_reg + {10'h000, !O_PROG_DATA_PIN_OE_N && !O_PROG_DATA_PIN} : 11'h000;
    age_next = (clk_reg && !I_PROG_CLOCK_PIN) ? 4'h0 : age_reg + {3'h0, age_reg != 4'hF};
  end
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      low_reg <= 11'h000;
      age_reg <= 4'hF;
      clk_reg <= 1'b0;
    end else begin
      low_reg <= low_next;
      age_reg <= age_next;
      clk_reg <= clk_next;
    end
  end
  a_ready_low_len: assert property ($fell(O_BUSY) |-> low_reg == 11'(READY_LOW_CYCLES))
    else $error("ready low pulse has the wrong length");
  a_busy_takes_line: assert property ($rose(O_BUSY) |-> !O_PROG_DATA_PIN_OE_N && O_PROG_DATA_PIN)
    else $error("busy without driving the line high");
  a_busy_holds_high: assert property (O_BUSY && O_PROG_DATA_PIN && !I_RSP_DONE |=>
    O_BUSY && O_PROG_DATA_PIN && !O_PROG_DATA_PIN_OE_N) else $error("busy level lost");
  a_done_to_ready: assert property (O_BUSY && O_PROG_DATA_PIN && I_RSP_DONE |=>
    !O_PROG_DATA_PIN && O_BUSY) else $error("no ready low after completion");
  a_line_only_busy: assert property ($fell(O_PROG_DATA_PIN_OE_N) |-> O_BUSY)
    else $error("device took the line unasked");
  a_flags_with_valid: assert property (O_CMD_FIRST || O_CMD_LAST |-> O_CMD_VALID)
    else $error("word flag without valid");
  a_valid_spacing: assert property (O_CMD_VALID |=> !O_CMD_VALID [*8])
    else $error("command words too close");
  a_last_sets_busy: assert property (O_CMD_VALID && O_CMD_LAST |-> O_BUSY)
    else $error("last word did not start processing");
  a_req_in_tx: assert property (O_RSP_DATA_REQ |-> !O_BUSY ##1 !O_RSP_DATA_REQ)
    else $error("data request outside response");
  a_bits_after_fall: assert property (!O_BUSY && !O_PROG_DATA_PIN_OE_N &&
    !$past(O_PROG_DATA_PIN_OE_N) && $changed(O_PROG_DATA_PIN) |-> age_reg <= 4'h6)
    else $error("response bit changed away from a falling edge");
endmodule
bind prog_exec_link prog_exec_link_asserts chk (.I_MCLK(I_MCLK), .I_RESET_N(I_RESET_N),
  .I_PROG_CLOCK_PIN(I_PROG_CLOCK_PIN), .I_RSP_DONE(I_RSP_DONE),
  .O_PROG_DATA_PIN(O_PROG_DATA_PIN), .O_PROG_DATA_PIN_OE_N(O_PROG_DATA_PIN_OE_N),
  .O_CMD_VALID(O_CMD_VALID), .O_CMD_FIRST(O_CMD_FIRST), .O_CMD_LAST(O_CMD_LAST),
  .O_BUSY(O_BUSY), .O_RSP_DATA_REQ(O_RSP_DATA_REQ));

// *** prog_exec_link_bench.sv ***
// Self-checking bench for the programming link device end.
`timescale 1ns/1ns
module prog_exec_link_bench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic rsp_done = 1'b0;
  logic rsp_query = 1'b0;
  logic [1:0] rsp_error = 2'h0;
  logic [15:0] dcount = 16'h0000;
  logic dvalid = 1'b0;
  logic [15:0] data = 16'h0000;
  logic pclk, line, dpin, oe_n, cmd_valid, first, last, busy, dreq;
  logic [15:0] cmd_word;
  int miscompares = 0;
  int samples_checked = 0;
  always #5 mclk = ~mclk;
  prog_exec_link uut (.I_MCLK(mclk), .I_RESET_N(rst_n), .I_CLK_EN(1'b1),
    .I_PROG_CLOCK_PIN(pclk), .I_PROG_DATA_PIN(line), .O_PROG_DATA_PIN(dpin),
    .O_PROG_DATA_PIN_OE_N(oe_n), .O_CMD_WORD(cmd_word), .O_CMD_VALID(cmd_valid),
    .O_CMD_FIRST(first), .O_CMD_LAST(last), .O_BUSY(busy), .I_RSP_DONE(rsp_done),
    .I_RSP_QUERY(rsp_query), .I_RSP_ERROR(rsp_error), .I_RSP_QUERY_BYTE(8'h5A),
    .I_RSP_DATA_COUNT(dcount), .O_RSP_DATA_REQ(dreq), .I_RSP_DATA_VALID(dvalid),
    .I_RSP_DATA(data));
  prog_master_model pm (.i_dev_pin(dpin), .i_dev_oe_n(oe_n), .o_pclk(pclk), .o_line(line));
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want) begin
      miscompares++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic close_out();
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic serve(input logic [15:0] w0, input logic [15:0] w1, input int n,
      input logic q, input logic [1:0] e, input logic [15:0] cnt, input logic [15:0] dat);
    int t;
    for (int k = 0; k < n; k++) begin
      t = 0;
      while (cmd_valid !== 1'b1 && t < 5000) begin
        @(negedge mclk);
        t++;
      end
      check({15'h0, cmd_valid}, 16'h0001);
      check(cmd_word, k == 0 ? w0 : w1);
      check({14'h0, first, last}, {14'h0, k == 0, k == n - 1});
      @(negedge mclk);
    end
    repeat (50) @(negedge mclk);
    check({13'h0, busy, oe_n, dpin}, 16'h0005);
    @(posedge mclk);
    rsp_done <= 1'b1;
    rsp_query <= q;
    rsp_error <= e;
    dcount <= cnt;
    @(posedge mclk);
    rsp_done <= 1'b0;
    @(negedge mclk);
    check({14'h0, oe_n, dpin}, 16'h0000);
    t = 0;
    while (cnt > 0 && dreq !== 1'b1 && t < 20000) begin
      @(negedge mclk);
      t++;
    end
    if (cnt > 0) begin
      check({15'h0, dreq}, 16'h0001);
      @(posedge mclk);
      dvalid <= 1'b1;
      data <= dat;
      @(posedge mclk);
      dvalid <= 1'b0;
    end
  endtask
  task automatic run_ex(input logic [15:0] w0, input logic [15:0] w1, input int n,
      input logic q, input logic [1:0] e, input logic [15:0] cnt, input logic [15:0] dat,
      input logic [15:0] r0);
    fork
      pm.exchange(w0, w1, n);
      serve(w0, w1, n, q, e, cnt, dat);
    join
    check(16'(pm.rsp_q.size()), cnt + 16'h0002);
    check(pm.rsp_q[0], r0);
    check(pm.rsp_q[1], cnt + 16'h0002);
    if (cnt > 0) check(pm.rsp_q[2], dat);
    check({14'h0, oe_n, dpin}, 16'h0003);
  endtask
  task automatic t_plain();
    run_ex(16'h0001, 16'h0000, 1, 1'b0, 2'h0, 16'h0000, 16'h0000, 16'h1000);
    $display("t_plain done");
  endtask
  task automatic t_two_words();
    run_ex(16'h1002, 16'h0001, 2, 1'b0, 2'h1, 16'h0001, 16'hA5C3, 16'h1101);
    $display("t_two_words done");
  endtask
  // Both other error codes fold to one status, and a query passes its byte through.
  // The first command carries a zero length field, which counts as one word.
  task automatic t_status();
    run_ex(16'h7000, 16'h0000, 1, 1'b0, 2'h2, 16'h0000, 16'h0000, 16'h1702);
    run_ex(16'h7001, 16'h0000, 1, 1'b0, 2'h3, 16'h0000, 16'h0000, 16'h1702);
    run_ex(16'hB001, 16'h0000, 1, 1'b1, 2'h0, 16'h0000, 16'h0000, 16'h1B5A);
    $display("t_status done");
  endtask
  // the bench times the whole run and gives up on a hang.
  initial begin
    #800000;
    miscompares++;
    close_out();
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_plain();
    t_two_words();
    t_status();
    close_out();
  end
endmodule

// *** prog_exec_pkg.sv ***
// Constants, field layouts and state encodings for the programming-executive serial link.
package prog_exec_pkg;
  localparam int WORD_W = 16;
  localparam int BIT_CNT_W = 4;
  localparam logic [3:0] LAST_BIT = 4'hF;
  // Command word layout: opcode in the top nibble, word count below it.
  localparam int CMD_OPC_MSB = 15;
  localparam int CMD_OPC_LSB = 12;
  localparam int CMD_LEN_MSB = 11;
  localparam int CMD_LEN_LSB = 0;
  // First response header word: pass marker, echoed opcode, status byte.
  localparam logic [3:0] RSP_PASS_NIBBLE = 4'h1;
  localparam logic [15:0] RSP_HDR_WORDS = 16'h0002;
  localparam logic [7:0] STATUS_OK = 8'h00;
  localparam logic [7:0] STATUS_VERIFY_FAIL = 8'h01;
  localparam logic [7:0] STATUS_OTHER_ERR = 8'h02;
  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_VERIFY = 2'h1;
  // Response-ready low pulse on the data pin.
  localparam int CLK_MHZ = 100;
  localparam int READY_LOW_US = 15;
  localparam int READY_LOW_CYCLES = READY_LOW_US * CLK_MHZ;
  localparam int TIMER_W = 11;
  localparam logic [TIMER_W-1:0] READY_LOW_LAST = TIMER_W'(READY_LOW_CYCLES - 1);
  typedef enum logic [1:0] {
    ST_RX = 2'h0,
    ST_BUSY = 2'h1,
    ST_READY = 2'h3,
    ST_TX = 2'h2
  } link_state_t;
endpackage

// *** prog_master_model.sv ***
// Behavioural programmer that masters the serial clock and the shared data wire.
`timescale 1ns/1ns
module prog_master_model (
  input wire logic i_dev_pin,
  input wire logic i_dev_oe_n,
  output logic o_pclk,
  output logic o_line
);
  // half period of 84 ticks keeps the clock below 1 MHz.
  localparam int HALF = 84;
  localparam int WAIT_20US = 3334;
  logic bclk = 1'b0;
  logic drv_en = 1'b0;
  logic drv_val = 1'b0;
  logic [15:0] rsp_q[$];
  always #3 bclk = ~bclk;
  initial o_pclk = 1'b0;
  // Contention reads as unknown; a free wire floats to the pull-up.
  assign o_line = (!i_dev_oe_n && drv_en) ? 1'bx :
    (!i_dev_oe_n ? i_dev_pin : (drv_en ? drv_val : 1'b1));
  task automatic ticks(input int n);
    repeat (n) @(posedge bclk);
  endtask
  // clock generated here, data moved after the fall, MSB first.
  task automatic send_word(input logic [15:0] w, input logic last);
    for (int i = 15; i >= 0; i--) begin
      drv_en <= 1'b1;
      drv_val <= w[i];
      ticks(HALF);
      o_pclk <= 1'b1;
      ticks(1);
      // let go just after the final rise, before the device grabs the wire.
      if (last && i == 0) drv_en <= 1'b0;
      ticks(HALF);
      o_pclk <= 1'b0;
      ticks(1);
    end
  endtask
  // response bits sampled at the rise.
  task automatic recv_word(output logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      ticks(HALF);
      w[i] = o_line;
      o_pclk <= 1'b1;
      ticks(HALF);
      o_pclk <= 1'b0;
    end
  endtask
  // one command, wait out the ready low, whole response up to 6 words, idle.
  task automatic exchange(input logic [15:0] w0, input logic [15:0] w1, input int n);
    logic [15:0] w;
    int t;
    rsp_q.delete();
    send_word(w0, n == 1);
    if (n > 1) send_word(w1, 1'b1);
    t = 0;
    while (o_line !== 1'b0 && t < 200000) begin
      ticks(1);
      t++;
    end
    ticks(WAIT_20US);
    for (int k = 0; k < 2 || (k < rsp_q[1] && k < 6); k++) begin
      recv_word(w);
      rsp_q.push_back(w);
    end
    ticks(HALF);
  endtask
endmodule
